// >>> shared/lpdc_consts.vh
// Summary of operation
// - give at least 2 stable clocks before raising CKE to leave self refresh.
// - all banks must be idle precharged before self refresh entry.
// - exit interval starts at the first rising edge after CKE goes high.
// - only NOP commands during the exit interval; valid commands after it.
// - mode register read is cs low, CA0-2 low, CA3 high at rising edge.
// - register number from CA1:CA0 falling edge and CA9:CA4 rising edge.
// - mode register read period is 2 clocks with only NOPs.
// - spacing from mode register read to write and to mode register write.
// - mode register read spacing after read or write bursts.
// - poll interval chosen so slope times total delay stays within 2 C.
// - mode register read allowed with banks active; write needs idle banks (the second write, for segMask, is sent without checking banksIdle).
`ifndef LPDC_CONSTS_VH
`define LPDC_CONSTS_VH
`define LPDC_CLK_MHZ 40
`define LPDC_TXSR_NS 140
`define LPDC_TXSR_CYC ((`LPDC_TXSR_NS * `LPDC_CLK_MHZ + 999) / 1000)
`define LPDC_SETTLE_CYC 2
`define LPDC_TMRR_CYC 2
`define LPDC_RL 8
`define LPDC_WL 4
`define LPDC_DQSCK_CYC 1
`define LPDC_MRR2MRW_CYC (`LPDC_RL + `LPDC_DQSCK_CYC + 4 / 2 + 1)
`define LPDC_MRR2WR_CYC (`LPDC_MRR2MRW_CYC - `LPDC_WL)
`define LPDC_TMRW_CYC 5
`define LPDC_CNT_W 8
`define LPDC_MR_BANKMASK 8'h10
`define LPDC_MR_SEGMASK 8'h11
`define LPDC_MR_TEMP 8'h04
`define LPDC_TEMP_MSB 2
`define LPDC_A_CTRL 4'h0
`define LPDC_A_MASKS 4'h4
`define LPDC_A_MRR 4'h8
`define LPDC_A_STAT 4'hc
`define LPDC_BIT_GO 0
`define LPDC_BIT_SREX 1
`define LPDC_BIT_MRR 2
`define LPDC_BIT_BUSY 0
`define LPDC_BIT_MRRDONE 1
`define LPDC_RESP_OK 2'h0
`define LPDC_RESP_ERR 2'h2
`endif

// >>> hw/lpdc_axil_regs.v
`timescale 1ns/1ps
`include "lpdc_consts.vh"
module lpdc_axil_regs (
    input wire mclk,
    input wire rst_n,
    input wire [3:0] awaddr,
    input wire awvalid,
    output reg awready,
    input wire [31:0] wdata,
    input wire [3:0] wstrb,
    input wire wvalid,
    output reg wready,
    output reg [1:0] bresp,
    output reg bvalid,
    input wire bready,
    input wire [3:0] araddr,
    input wire arvalid,
    output reg arready,
    output reg [31:0] rdata,
    output reg [1:0] rresp,
    output reg rvalid,
    input wire rready,
    output reg [7:0] bankMask,
    output reg [7:0] segMask,
    output reg [7:0] mrrAddr,
    output reg goPulse,
    output reg srExitPulse,
    output reg mrrPulse,
    input wire busy,
    input wire [7:0] mrrData,
    input wire mrrDone
)
;
    reg [3:0] awq;
    reg awHave;
    reg [31:0] wq;
    reg wHave;
    reg doneSticky;
    wire doWrite = awHave && wHave && !bvalid;
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            awready <= 1'b0;
            wready <= 1'b0;
            awHave <= 1'b0;
            wHave <= 1'b0;
            awq <= 4'h0;
            wq <= 32'h0;
            bvalid <= 1'b0;
            bresp <= `LPDC_RESP_OK;
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h0;
            rresp <= `LPDC_RESP_OK;
            bankMask <= 8'h00;
            segMask <= 8'h00;
            mrrAddr <= `LPDC_MR_TEMP;
            goPulse <= 1'b0;
            srExitPulse <= 1'b0;
            mrrPulse <= 1'b0;
            doneSticky <= 1'b0;
        end else begin
            goPulse <= 1'b0;
            srExitPulse <= 1'b0;
            mrrPulse <= 1'b0;
            awready <= !awHave && !awready && awvalid;
            wready <= !wHave && !wready && wvalid;
            if (awvalid && awready) begin
                awHave <= 1'b1;
                awq <= awaddr;
            end
            if (wvalid && wready) begin
                wHave <= 1'b1;
                wq <= wdata;
            end
            if (bvalid && bready)
                bvalid <= 1'b0;
            if (doWrite) begin
                awHave <= 1'b0;
                wHave <= 1'b0;
                bvalid <= 1'b1;
                bresp <= `LPDC_RESP_OK;
                if (awq == `LPDC_A_CTRL) begin
                    goPulse <= wq[`LPDC_BIT_GO];
                    srExitPulse <= wq[`LPDC_BIT_SREX];
                    mrrPulse <= wq[`LPDC_BIT_MRR];
                end else if (awq == `LPDC_A_MASKS) begin
                    bankMask <= wq[7:0];
                    segMask <= wq[15:8];
                end else if (awq == `LPDC_A_MRR) begin
                    mrrAddr <= wq[7:0];
                end else if (awq != `LPDC_A_STAT) begin
                    bresp <= `LPDC_RESP_ERR;
                end
            end
            arready <= !rvalid && !arready && arvalid;
            if (rvalid && rready)
                rvalid <= 1'b0;
            if (arvalid && arready) begin
                rvalid <= 1'b1;
                rresp <= `LPDC_RESP_OK;
                if (araddr == `LPDC_A_MASKS) begin
                    rdata <= {16'h0, segMask, bankMask};
                end else if (araddr == `LPDC_A_MRR) begin
                    rdata <= {16'h0, mrrData, mrrAddr};
                end else if (araddr == `LPDC_A_STAT) begin
                    rdata <= {30'h0, doneSticky, busy};
                end else if (araddr == `LPDC_A_CTRL) begin
                    rdata <= 32'h0;
                end else begin
                    rdata <= 32'h0;
                    rresp <= `LPDC_RESP_ERR;
                end
            end
            // set wins over clear on read of status
            if (mrrDone)
                doneSticky <= 1'b1;
            else if (arvalid && arready && araddr == `LPDC_A_STAT)
                doneSticky <= 1'b0;
        end
    end
endmodule

// >>> hw/lpdc_ctrl.v
`timescale 1ns/1ps
`include "lpdc_consts.vh"
module lpdc_ctrl (
    input wire mclk,
    input wire rst_n,
    input wire [3:0] awaddr,
    input wire awvalid,
    output wire awready,
    input wire [31:0] wdata,
    input wire [3:0] wstrb,
    input wire wvalid,
    output wire wready,
    output wire [1:0] bresp,
    output wire bvalid,
    input wire bready,
    input wire [3:0] araddr,
    input wire arvalid,
    output wire arready,
    output wire [31:0] rdata,
    output wire [1:0] rresp,
    output wire rvalid,
    input wire rready,
    input wire banksIdle,
    output reg cke,
    output reg csN,
    output reg [9:0] caRise,
    output reg [9:0] caFall,
    output reg clkRun,
    input wire [7:0] dqIn,
    input wire dqsIn
);
    localparam ST_IDLE = 3'd0;
    localparam ST_MRW = 3'd1;
    localparam ST_SETTLE = 3'd2;
    localparam ST_XSR = 3'd3;
    localparam ST_MRR = 3'd4;
    localparam ST_WAIT = 3'd5;
    localparam ST_SREF = 3'd6;
    wire [7:0] bankMask;
    wire [7:0] segMask;
    wire [7:0] mrrAddr;
    wire goPulse;
    wire srExitPulse;
    wire mrrPulse;
    reg [2:0] state;
    reg [`LPDC_CNT_W-1:0] cnt;
    reg which;
    reg [7:0] mrrData;
    reg mrrDone;
    lpdc_axil_regs lpdc_axil_regs_inst (
        .mclk(mclk),
        .rst_n(rst_n),
        .awaddr(awaddr),
        .awvalid(awvalid),
        .awready(awready),
        .wdata(wdata),
        .wstrb(wstrb),
        .wvalid(wvalid),
        .wready(wready),
        .bresp(bresp),
        .bvalid(bvalid),
        .bready(bready),
        .araddr(araddr),
        .arvalid(arvalid),
        .arready(arready),
        .rdata(rdata),
        .rresp(rresp),
        .rvalid(rvalid),
        .rready(rready),
        .bankMask(bankMask),
        .segMask(segMask),
        .mrrAddr(mrrAddr),
        .goPulse(goPulse),
        .srExitPulse(srExitPulse),
        .mrrPulse(mrrPulse),
        .busy(state != ST_IDLE && state != ST_SREF),
        .mrrData(mrrData),
        .mrrDone(mrrDone)
    );
    // mode register write command: CA0..3 low, register and data split by edge
    function [19:0] mrwCmd;
        input [7:0] ma;
        input [7:0] op;
        begin
            mrwCmd = {ma[5:0], 4'h0, op, ma[7:6]};
        end
    endfunction
    // counter load width-safe
    function [`LPDC_CNT_W-1:0] cyc;
        input integer n;
        begin
            cyc = n[`LPDC_CNT_W-1:0];
        end
    endfunction
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            cnt <= {`LPDC_CNT_W{1'b0}};
            which <= 1'b0;
            cke <= 1'b1;
            csN <= 1'b1;
            caRise <= 10'h000;
            caFall <= 10'h000;
            clkRun <= 1'b1;
            mrrData <= 8'h00;
            mrrDone <= 1'b0;
        end else begin
            mrrDone <= 1'b0;
            csN <= 1'b1;
            caRise <= 10'h000;
            caFall <= 10'h000;
            if (cnt != {`LPDC_CNT_W{1'b0}})
                cnt <= cnt - 1'b1;
            case (state)
                ST_IDLE: begin
                    if (goPulse && banksIdle) begin
                        csN <= 1'b0;
                        {caRise, caFall} <= mrwCmd(`LPDC_MR_BANKMASK, bankMask);
                        which <= 1'b0;
                        cnt <= cyc(`LPDC_TMRW_CYC);
                        state <= ST_MRW;
                    end else if (mrrPulse) begin
                        csN <= 1'b0;
                        caRise <= {mrrAddr[5:0], 4'h8};
                        caFall <= {8'h00, mrrAddr[7:6]};
                        cnt <= cyc(`LPDC_RL);
                        state <= ST_MRR;
                    end
                end
                ST_MRW: begin
                    // nops for tMRW between commands
                    if (cnt == {`LPDC_CNT_W{1'b0}}) begin
                        if (!which) begin
                            csN <= 1'b0;
                            {caRise, caFall} <= mrwCmd(`LPDC_MR_SEGMASK, segMask);
                            which <= 1'b1;
                            cnt <= cyc(`LPDC_TMRW_CYC);
                        end else if (banksIdle) begin
                            // self refresh entry with banks idle
                            csN <= 1'b0;
                            caRise <= 10'h004;
                            cke <= 1'b0;
                            state <= ST_SREF;
                        end
                    end
                end
                ST_SREF: begin
                    clkRun <= 1'b0;
                    if (srExitPulse) begin
                        clkRun <= 1'b1;
                        cnt <= cyc(`LPDC_SETTLE_CYC);
                        state <= ST_SETTLE;
                    end
                end
                ST_SETTLE: begin
                    if (cnt == {`LPDC_CNT_W{1'b0}}) begin
                        cke <= 1'b1;
                        cnt <= cyc(`LPDC_TXSR_CYC);
                        state <= ST_XSR;
                    end
                end
                ST_XSR: begin
                    if (cnt == {`LPDC_CNT_W{1'b0}}) begin
                        state <= ST_IDLE;
                    end
                end
                ST_MRR: begin
                    if (cnt == {`LPDC_CNT_W{1'b0}} && dqsIn) begin
                        mrrData <= dqIn;
                        mrrDone <= 1'b1;
                        cnt <= cyc(`LPDC_MRR2MRW_CYC - `LPDC_RL);
                        state <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (cnt == {`LPDC_CNT_W{1'b0}})
                        state <= ST_IDLE;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end
endmodule

// >>> dv/lpdc_chk.sv
`timescale 1ns/1ps
module lpdc_chk (
    input wire mclk,
    input wire rst_n,
    input wire banksIdle,
    input wire cke,
    input wire csN,
    input wire [9:0] caRise,
    input wire [9:0] caFall,
    input wire clkRun
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    wire mrr = !csN && caRise[3:0] == 4'h8;
    wire mrw = !csN && cke && caRise[3:0] == 4'h0;
    wire sre = !csN && !cke && caRise[2:0] == 3'h4;
    property p_mrr_nop; mrr |=> csN; endproperty
    a_mrr_nop: assert property (p_mrr_nop) else $error("command in mrr period");
    property p_mrw_idle; mrw |-> banksIdle; endproperty
    a_mrw_idle: assert property (p_mrw_idle) else $error("mrw with active banks");
    property p_sre_idle; sre |-> banksIdle && $past(cke); endproperty
    a_sre_idle: assert property (p_sre_idle) else $error("bad self refresh entry");
    property p_settle; $rose(cke) |-> $past(clkRun, 1) && $past(clkRun, 2); endproperty
    a_settle: assert property (p_settle) else $error("clock not settled");
    property p_txsr; $rose(cke) |-> csN [*6]; endproperty
    a_txsr: assert property (p_txsr) else $error("command in exit interval");
    property p_mrr_mrw; mrr |-> not (##[1:11] mrw); endproperty
    a_mrr_mrw: assert property (p_mrr_mrw) else $error("mrw too soon after mrr");
    property p_clk_stop; !clkRun |-> !cke; endproperty
    a_clk_stop: assert property (p_clk_stop) else $error("clock stopped outside");
    property p_ca_idle; csN |-> caRise == 10'h0 && caFall == 10'h0; endproperty
    a_ca_idle: assert property (p_ca_idle) else $error("ca busy without select");
endmodule

// >>> dv/lpdc_mem_model.sv
`timescale 1ns/1ps
`include "lpdc_consts.vh"
module lpdc_mem_model #(
    parameter [2:0] TEMP_CODE = 3'h3
) (
    input wire mclk,
    input wire rst_n,
    input wire cke,
    input wire csN,
    input wire [9:0] caRise,
    input wire [9:0] caFall,
    output reg [7:0] dqIn,
    output reg dqsIn
);
    reg [7:0] bankMask;
    reg [7:0] segMask;
    reg [7:0] mrData;
    reg [4:0] cnt;
    reg patB;
    wire [7:0] ma = {caFall[1:0], caRise[9:4]};
    wire mrr = !csN && cke && caRise[3:0] == 4'h8;
    wire mrw = !csN && cke && caRise[3:0] == 4'h0;
    function kept(input [2:0] b, input [2:0] s);
        kept = !bankMask[b] && !segMask[s];
    endfunction
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 5'h0;
            dqsIn <= 1'b0;
            dqIn <= 8'h00;
        end else begin
            cnt <= mrr ? 5'h1 : (cnt == 0 || cnt == `LPDC_RL + 3) ? 5'h0 : cnt + 5'h1;
            dqsIn <= cnt >= `LPDC_RL && !cnt[0];
            // pattern b holds on odd beats
            dqIn <= cnt == `LPDC_RL ? mrData : (patB && cnt[0]) ? dqIn : ~dqIn;
        end
    end
    always @(posedge mclk) begin
        if (mrw && ma == `LPDC_MR_BANKMASK)
            bankMask <= caFall[9:2];
        if (mrw && ma == `LPDC_MR_SEGMASK)
            segMask <= caFall[9:2];
        if (mrr) begin
            mrData <= ma == `LPDC_MR_TEMP ? {5'h0, TEMP_CODE} :
                ma == 8'h20 ? 8'hff : ma == 8'h28 ? 8'h00 : ~dqIn;
            patB <= ma == 8'h28;
        end
    end
endmodule

// >>> dv/lpdc_ctrl_tb.sv
`timescale 1ns/1ps
`include "lpdc_consts.vh"
module lpdc_ctrl_tb;
    reg mclk = 1'b0, rst_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    reg arvalid = 1'b0, rready = 1'b0, banksIdle = 1'b1;
    reg [3:0] awaddr = 4'h0, araddr = 4'h0;
    reg [31:0] wdata = 32'h0, d;
    reg [1:0] r;
    reg [23:0] mraTab = 24'h282004, mreTab = 24'h00ff03;
    wire awready, wready, bvalid, arready, rvalid, cke, csN, clkRun, dqsIn;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [9:0] caRise, caFall;
    wire [7:0] dqIn;
    integer numErrors = 0, testsRun = 0, i;
    always #12.5 mclk = ~mclk;
    lpdc_ctrl lpdc_ctrl_inst (.mclk, .rst_n, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hf),
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
        .rvalid, .rready, .banksIdle, .cke, .csN, .caRise, .caFall, .clkRun, .dqIn, .dqsIn);
    lpdc_mem_model #(.TEMP_CODE(3'h3)) lpdc_mem_model_inst (.mclk, .rst_n, .cke, .csN,
        .caRise, .caFall, .dqIn, .dqsIn);
    task chk(input [63:0] nm, input [31:0] e, input [31:0] g);
        begin
            testsRun = testsRun + 1;
            if (g !== e) begin
                numErrors = numErrors + 1;
                $display("BAD %0s exp %h got %h", nm, e, g);
            end
        end
    endtask
    task wr(input [3:0] a, input [31:0] v);
        begin
            awaddr <= a;
            wdata <= v;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
            do begin
                @(posedge mclk);
                if (awready) awvalid <= 1'b0;
                if (wready) wvalid <= 1'b0;
            end while (!bvalid);
            bready <= 1'b0;
            @(posedge mclk);
        end
    endtask
    task rd(input [3:0] a);
        begin
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
            do begin
                @(posedge mclk);
                if (arready) arvalid <= 1'b0;
            end while (!rvalid);
            d = rdata;
            r = rresp;
            rready <= 1'b0;
            @(posedge mclk);
        end
    endtask
    task poll(input integer b, input v);
        begin
            rd(`LPDC_A_STAT);
            while (d[b] !== v) rd(`LPDC_A_STAT);
        end
    endtask
    task tallyAndFinish;
        begin
            $display("checks %0d mismatches %0d", testsRun, numErrors);
            if (numErrors == 0 && testsRun > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    initial begin
        #(25 * 20000);
        numErrors = numErrors + 1;
        $display("test timeout");
        tallyAndFinish;
    end
    initial begin
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        rd(`LPDC_A_STAT);
        chk("stat", 32'h0, d);
        rd(`LPDC_A_MRR);
        chk("mrraddr", 32'h04, d[7:0]);
        rd(4'h2);
        chk("resp", `LPDC_RESP_ERR, r);
        wr(4'h2, 32'h0);
        chk("bresp", `LPDC_RESP_ERR, bresp);
        $display("test reset done");
        wr(`LPDC_A_MASKS, 32'h8482);
        chk("bresp", `LPDC_RESP_OK, bresp);
        rd(`LPDC_A_MASKS);
        chk("masks", 32'h8482, d);
        wr(`LPDC_A_CTRL, 32'h1);
        poll(`LPDC_BIT_BUSY, 1'b0);
        chk("bmask", 8'h82, lpdc_mem_model_inst.bankMask);
        chk("smask", 8'h84, lpdc_mem_model_inst.segMask);
        chk("keep00", 1'b1, lpdc_mem_model_inst.kept(3'd0, 3'd0));
        chk("keep10", 1'b0, lpdc_mem_model_inst.kept(3'd1, 3'd0));
        chk("keep02", 1'b0, lpdc_mem_model_inst.kept(3'd0, 3'd2));
        chk("clkrun", 1'b0, clkRun);
        chk("cke", 1'b0, cke);
        wr(`LPDC_A_CTRL, 32'h2);
        poll(`LPDC_BIT_BUSY, 1'b0);
        chk("cke", 1'b1, cke);
        chk("clkrun", 1'b1, clkRun);
        $display("test self refresh done");
        banksIdle <= 1'b0;
        for (i = 0; i < 3; i = i + 1) begin
            wr(`LPDC_A_MRR, {24'h0, mraTab[i*8 +: 8]});
            wr(`LPDC_A_CTRL, 32'h4);
            poll(`LPDC_BIT_MRRDONE, 1'b1);
            rd(`LPDC_A_MRR);
            chk("mrrdata", mreTab[i*8 +: 8], d[15:8]);
        end
        rd(`LPDC_A_STAT);
        chk("done", 1'b0, d[`LPDC_BIT_MRRDONE]);
        $display("test mrr done");
        wr(`LPDC_A_MASKS, 32'h0);
        wr(`LPDC_A_CTRL, 32'h1);
        rd(`LPDC_A_STAT);
        chk("busy", 1'b0, d[`LPDC_BIT_BUSY]);
        chk("bmask", 8'h82, lpdc_mem_model_inst.bankMask);
        chk("cke", 1'b1, cke);
        $display("test refused entry done");
        tallyAndFinish;
    end
endmodule
bind lpdc_ctrl lpdc_chk lpdc_chk_inst (.mclk, .rst_n, .banksIdle, .cke, .csN, .caRise,
    .caFall, .clkRun);
